// >>> rtl/link_param_pkg.sv
// constants, types and layout shared by the link parameter checker
//
// Functional notes
// - only listed decimation ratios per lanes, converters, octets and rate band
// - frames per multiframe times octets per frame is a multiple of 4
// - frames per multiframe 20/12/8/4 minimum by frame size, up to 32, step 4
// - frame holds fixed octets and samples, multiframe spans configured lanes
// - 8-bit words: resolution 7 or 8, zero or one control bit
// - output rate equals sample clock divided by decimation ratio
// - one or two converters on one, two or four lanes, 2.5x to 20x
package link_param_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;

    // register offsets
    localparam logic [15:0] OFF_PLL_RANGE = 16'h056e;
    localparam logic [15:0] OFF_LANES     = 16'h0580;
    localparam logic [15:0] OFF_CONV      = 16'h0581;
    localparam logic [15:0] OFF_OCTETS    = 16'h0582;
    localparam logic [15:0] OFF_FRAMES    = 16'h0583;
    localparam logic [15:0] OFF_RES       = 16'h0584;
    localparam logic [15:0] OFF_CTRL_BITS = 16'h0585;
    localparam logic [15:0] OFF_DCM       = 16'h0586;
    localparam logic [15:0] OFF_LANE_RATE = 16'h0587;
    localparam logic [15:0] OFF_SAMPLE_CK = 16'h0588;
    localparam logic [15:0] OFF_CONTROL   = 16'h0589;
    localparam logic [15:0] OFF_STATUS    = 16'h058a;

    // control and status bit positions
    localparam int CTL_APPLY  = 0;
    localparam int CTL_STOP   = 1;
    localparam int ST_LIVE_B  = 0;
    localparam int ST_ERR_B   = 1;
    localparam int ST_ERRS_LO = 2;

    // reset values
    localparam logic [7:0]  PLL_RANGE_RST = 8'h00;
    localparam logic [7:0]  CFG_BYTE_RST  = 8'h01;
    localparam logic [15:0] CFG_WORD_RST  = 16'h0000;

    // lane rate is held in half-Mbps units
    localparam logic [15:0] RATE_MIN_HALF = 16'h0d2f;
    localparam logic [15:0] RATE_MAX_HALF = 16'h7918;
    localparam logic [15:0] BAND1_LO     = 16'h1a5e;
    localparam logic [15:0] BAND2_LO     = 16'h34bc;
    localparam logic [15:0] BAND3_LO     = 16'h6978;
    localparam logic [15:0] BAND3_HI     = 16'h7d00;
    localparam logic [7:0]  SLR_DIV_HALF = 8'h50;
    localparam logic [11:0] LCM_MAX      = 12'h040;

    // pll range codes per band, band 0 lowest
    localparam logic [3:0][7:0] PLL_CODE = {8'h30, 8'h00, 8'h10, 8'h50};

    // frame and word limits
    localparam logic [7:0] K_MAX    = 8'h20;
    localparam logic [1:0] K_STEP_M = 2'h3;
    localparam logic [7:0] K_MIN_F1 = 8'h14;
    localparam logic [7:0] K_MIN_F2 = 8'h0c;
    localparam logic [7:0] K_MIN_F4 = 8'h08;
    localparam logic [7:0] K_MIN_F8 = 8'h04;
    localparam logic [7:0] RES_MIN  = 8'h07;
    localparam logic [7:0] RES_MAX  = 8'h08;
    localparam logic [7:0] CS_MAX   = 8'h01;
    localparam logic [7:0] WORD_W   = 8'h08;
    localparam logic [7:0] VAL1     = 8'h01;
    localparam logic [7:0] VAL2     = 8'h02;
    localparam logic [7:0] VAL4     = 8'h04;
    localparam logic [7:0] VAL8     = 8'h08;
    localparam logic [7:0] VAL16    = 8'h10;
    localparam logic [7:0] DCM_LIM  = 8'h20;

    // lane rate families, twice the lane rate to output rate factor
    typedef enum logic [2:0] {
        GRP_NONE, GRP_X10, GRP_X10W, GRP_X5, GRP_X2P5, GRP_X20
    } grp_t;
    localparam logic [5:0] MULT2_X10  = 6'h14;
    localparam logic [5:0] MULT2_X5   = 6'h0a;
    localparam logic [5:0] MULT2_X2P5 = 6'h05;
    localparam logic [5:0] MULT2_X20  = 6'h28;
    localparam logic [3:0] KF_X10     = 4'h2;
    localparam logic [3:0] KF_X5      = 4'h4;
    localparam logic [3:0] KF_X2P5    = 4'h8;
    localparam logic [3:0] KF_X20     = 4'h1;

    // legal decimation ratios, bit n means ratio n, index is band
    localparam logic [3:0][31:0] MASK_X10  = {32'h0000_0006, 32'h0000_001e, 32'h0000_017e, 32'h0000_157e};
    localparam logic [3:0][31:0] MASK_X10W = {32'h0000_0006, 32'h0000_001e, 32'h0000_017e, 32'h0001_957e};
    localparam logic [3:0][31:0] MASK_X5   = {32'h0000_0002, 32'h0000_0006, 32'h0000_001e, 32'h0000_017e};
    localparam logic [3:0][31:0] MASK_X2P5 = {32'h0000_0000, 32'h0000_0002, 32'h0000_0006, 32'h0000_001e};
    localparam logic [3:0][31:0] MASK_X20  = {32'h0000_001e, 32'h0000_017e, 32'h0001_957e, 32'h4111_9574};

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_LIVE  = 4'b0100,
        ST_FAULT = 4'b1000
    } fsm_t;

    typedef struct packed {
        logic [7:0]  lanes;
        logic [7:0]  conv;
        logic [7:0]  octets;
        logic [7:0]  frames;
        logic [7:0]  res;
        logic [7:0]  ctrl_bits;
        logic [7:0]  chip_decimation_ratio;
        logic [15:0] lane_half;
        logic [15:0] fs_mhz;
    } cfg_t;

    typedef struct packed {
        logic word;
        logic pll;
        logic mf;
        logic divider;
        logic rate;
        logic table_miss;
    } err_t;

endpackage : link_param_pkg

// >>> rtl/lane_band.sv
// lane rate band decode and expected pll range code
`timescale 1ns/100ps
module lane_band (
    input  wire logic [15:0] lane_half,
    output logic      [1:0]  band,
    output logic             in_range,
    output logic      [7:0]  pll_code
);
    always_comb begin
        in_range = (lane_half >= link_param_pkg::RATE_MIN_HALF) && (lane_half <= link_param_pkg::RATE_MAX_HALF);
        if (lane_half > link_param_pkg::BAND3_LO) begin
            band = 2'h3;
        end else if (lane_half >= link_param_pkg::BAND2_LO) begin
            band = 2'h2;
        end else if (lane_half >= link_param_pkg::BAND1_LO) begin
            band = 2'h1;
        end else begin
            band = 2'h0;
        end
        pll_code = link_param_pkg::PLL_CODE[band];
    end
endmodule : lane_band

// >>> rtl/cfg_table.sv
// transport layout lookup: family, rate factor and legal decimation
`timescale 1ns/100ps
module cfg_table (
    input  wire link_param_pkg::cfg_t cfg,
    input  wire logic [1:0]           band,
    output link_param_pkg::grp_t      grp,
    output logic                      table_ok,
    output logic [5:0]                mult2,
    output logic [3:0]                k_fac,
    output logic [7:0]                samples
);
    function automatic logic dcm_legal(input logic [3:0][31:0] mask, input logic [1:0] b, input logic [7:0] d);
        dcm_legal = (d < link_param_pkg::DCM_LIM) && mask[b][d[4:0]];
    endfunction : dcm_legal

    logic m1;
    logic m2;
    logic f12;
    logic f124;

    always_comb begin
        m1   = cfg.conv == link_param_pkg::VAL1;
        m2   = cfg.conv == link_param_pkg::VAL2;
        f12  = (cfg.octets == link_param_pkg::VAL1) || (cfg.octets == link_param_pkg::VAL2);
        f124 = f12 || (cfg.octets == link_param_pkg::VAL4);
        grp = link_param_pkg::GRP_NONE;
        if (m1 && cfg.lanes == link_param_pkg::VAL1 && f12) begin
            grp = link_param_pkg::GRP_X10;
        end else if (m1 && cfg.lanes == link_param_pkg::VAL2 && f124) begin
            grp = link_param_pkg::GRP_X5;
        end else if (m1 && cfg.lanes == link_param_pkg::VAL4 && f12) begin
            grp = link_param_pkg::GRP_X2P5;
        end else if (m2 && cfg.lanes == link_param_pkg::VAL1 && cfg.octets == link_param_pkg::VAL2) begin
            grp = link_param_pkg::GRP_X20;
        end else if (m2 && cfg.lanes == link_param_pkg::VAL2 && f12) begin
            grp = link_param_pkg::GRP_X10W;
        end else if (m2 && cfg.lanes == link_param_pkg::VAL4 && f124) begin
            grp = link_param_pkg::GRP_X5;
        end
        unique case (grp)
            link_param_pkg::GRP_X10: begin
                table_ok = dcm_legal(link_param_pkg::MASK_X10, band, cfg.chip_decimation_ratio);
                mult2    = link_param_pkg::MULT2_X10;
                k_fac    = link_param_pkg::KF_X10;
            end
            link_param_pkg::GRP_X10W: begin
                table_ok = dcm_legal(link_param_pkg::MASK_X10W, band, cfg.chip_decimation_ratio);
                mult2    = link_param_pkg::MULT2_X10;
                k_fac    = link_param_pkg::KF_X10;
            end
            link_param_pkg::GRP_X5: begin
                table_ok = dcm_legal(link_param_pkg::MASK_X5, band, cfg.chip_decimation_ratio);
                mult2    = link_param_pkg::MULT2_X5;
                k_fac    = link_param_pkg::KF_X5;
            end
            link_param_pkg::GRP_X2P5: begin
                table_ok = dcm_legal(link_param_pkg::MASK_X2P5, band, cfg.chip_decimation_ratio);
                mult2    = link_param_pkg::MULT2_X2P5;
                k_fac    = link_param_pkg::KF_X2P5;
            end
            link_param_pkg::GRP_X20: begin
                table_ok = dcm_legal(link_param_pkg::MASK_X20, band, cfg.chip_decimation_ratio);
                mult2    = link_param_pkg::MULT2_X20;
                k_fac    = link_param_pkg::KF_X20;
            end
            default: begin
                table_ok = 1'b0;
                mult2    = link_param_pkg::MULT2_X10;
                k_fac    = link_param_pkg::KF_X10;
            end
        endcase
        samples = m2 ? 8'((cfg.octets * cfg.lanes) >> 1) : 8'(cfg.octets * cfg.lanes);
    end
endmodule : cfg_table

// >>> rtl/jesd_link_param_checker.sv
// link parameter register file, checker and apply state machine
`timescale 1ns/100ps
module jesd_link_param_checker (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             link_enable,
    output logic             config_error,
    output logic      [7:0]  pll_range,
    output logic      [7:0]  samples_per_frame
);
    typedef struct packed {
        link_param_pkg::fsm_t fsm;
        link_param_pkg::cfg_t cfg;
        logic [7:0]           pll_reg;
        link_param_pkg::err_t err;
        logic                 link_en;
        logic                 cfg_err;
        logic [7:0]           pll_live;
        logic [7:0]           samples;
        logic [15:0]          rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    ////////////////////////////////////////////////////////////////////////////////
    // lookups

    logic [1:0]           band;
    logic                 in_range;
    logic [7:0]           pll_code;
    link_param_pkg::grp_t grp;
    logic                 table_ok;
    logic [5:0]           mult2;
    logic [3:0]           k_fac;
    logic [7:0]           samples;

    lane_band u_band (
        .lane_half (st_reg.cfg.lane_half),
        .band      (band),
        .in_range  (in_range),
        .pll_code  (pll_code)
    );

    cfg_table u_table (
        .cfg      (st_reg.cfg),
        .band     (band),
        .grp      (grp),
        .table_ok (table_ok),
        .mult2    (mult2),
        .k_fac    (k_fac),
        .samples  (samples)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // parameter checks

    logic [23:0]         rate_x_dcm;
    logic [23:0]         fs_x_mult;
    logic [23:0]         fs_x_div;
    logic [11:0]         lcm_val;
    logic [7:0]          k_min;
    link_param_pkg::err_t err_now;

    always_comb begin
        rate_x_dcm = 24'(st_reg.cfg.lane_half * st_reg.cfg.chip_decimation_ratio);
        fs_x_mult  = 24'(st_reg.cfg.fs_mhz * mult2);
        fs_x_div   = 24'(st_reg.cfg.fs_mhz * link_param_pkg::SLR_DIV_HALF);
        // lcm reduces to factor times ratio
        lcm_val    = 12'(k_fac * st_reg.cfg.chip_decimation_ratio);
        unique case (st_reg.cfg.octets)
            link_param_pkg::VAL1: k_min = link_param_pkg::K_MIN_F1;
            link_param_pkg::VAL2: k_min = link_param_pkg::K_MIN_F2;
            link_param_pkg::VAL4: k_min = link_param_pkg::K_MIN_F4;
            default:              k_min = link_param_pkg::K_MIN_F8;
        endcase
        err_now.table_miss = !table_ok;
        err_now.rate       = !in_range;
        err_now.divider    = (st_reg.cfg.lane_half > fs_x_div) || (lcm_val > link_param_pkg::LCM_MAX)
                           || (rate_x_dcm != fs_x_mult) || (st_reg.cfg.chip_decimation_ratio == '0);
        err_now.mf         = (st_reg.cfg.frames[1:0] & link_param_pkg::K_STEP_M) != '0
                           || st_reg.cfg.frames < k_min || st_reg.cfg.frames > link_param_pkg::K_MAX
                           || !(st_reg.cfg.octets inside {link_param_pkg::VAL1, link_param_pkg::VAL2,
                                link_param_pkg::VAL4, link_param_pkg::VAL8, link_param_pkg::VAL16});
        err_now.pll        = st_reg.pll_reg != pll_code;
        err_now.word       = st_reg.cfg.res < link_param_pkg::RES_MIN || st_reg.cfg.res > link_param_pkg::RES_MAX
                           || st_reg.cfg.ctrl_bits > link_param_pkg::CS_MAX
                           || 8'(st_reg.cfg.res + st_reg.cfg.ctrl_bits) > link_param_pkg::WORD_W;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register access and state machine

    logic cfg_open;

    always_comb begin
        st_next  = st_reg;
        cfg_open = (st_reg.fsm == link_param_pkg::ST_IDLE) || (st_reg.fsm == link_param_pkg::ST_FAULT);
        if (wr) begin
            if (cfg_open) begin
                unique case (addr)
                    link_param_pkg::OFF_PLL_RANGE: st_next.pll_reg       = wdata[7:0];
                    link_param_pkg::OFF_LANES:     st_next.cfg.lanes     = wdata[7:0];
                    link_param_pkg::OFF_CONV:      st_next.cfg.conv      = wdata[7:0];
                    link_param_pkg::OFF_OCTETS:    st_next.cfg.octets    = wdata[7:0];
                    link_param_pkg::OFF_FRAMES:    st_next.cfg.frames    = wdata[7:0];
                    link_param_pkg::OFF_RES:       st_next.cfg.res       = wdata[7:0];
                    link_param_pkg::OFF_CTRL_BITS: st_next.cfg.ctrl_bits = wdata[7:0];
                    link_param_pkg::OFF_DCM:       st_next.cfg.chip_decimation_ratio       = wdata[7:0];
                    link_param_pkg::OFF_LANE_RATE: st_next.cfg.lane_half = wdata;
                    link_param_pkg::OFF_SAMPLE_CK: st_next.cfg.fs_mhz    = wdata;
                    default: ;
                endcase
            end
            if (addr == link_param_pkg::OFF_CONTROL) begin
                if (wdata[link_param_pkg::CTL_STOP]) begin
                    st_next.fsm     = link_param_pkg::ST_IDLE;
                    st_next.link_en = 1'b0;
                end else if (wdata[link_param_pkg::CTL_APPLY] && cfg_open) begin
                    st_next.fsm     = link_param_pkg::ST_CHECK;
                    st_next.err     = '0;
                    st_next.cfg_err = 1'b0;
                end
            end
        end
        if (st_reg.fsm == link_param_pkg::ST_CHECK) begin
            st_next.err     = err_now;
            st_next.samples = samples;
            if (err_now == '0) begin
                st_next.fsm      = link_param_pkg::ST_LIVE;
                st_next.link_en  = 1'b1;
                st_next.pll_live = st_reg.pll_reg;
            end else begin
                st_next.fsm     = link_param_pkg::ST_FAULT;
                st_next.cfg_err = 1'b1;
            end
        end
        st_next.rdata = '0;
        if (rd) begin
            unique case (addr)
                link_param_pkg::OFF_PLL_RANGE: st_next.rdata = {8'h00, st_reg.pll_reg};
                link_param_pkg::OFF_LANES:     st_next.rdata = {8'h00, st_reg.cfg.lanes};
                link_param_pkg::OFF_CONV:      st_next.rdata = {8'h00, st_reg.cfg.conv};
                link_param_pkg::OFF_OCTETS:    st_next.rdata = {8'h00, st_reg.cfg.octets};
                link_param_pkg::OFF_FRAMES:    st_next.rdata = {8'h00, st_reg.cfg.frames};
                link_param_pkg::OFF_RES:       st_next.rdata = {8'h00, st_reg.cfg.res};
                link_param_pkg::OFF_CTRL_BITS: st_next.rdata = {8'h00, st_reg.cfg.ctrl_bits};
                link_param_pkg::OFF_DCM:       st_next.rdata = {8'h00, st_reg.cfg.chip_decimation_ratio};
                link_param_pkg::OFF_LANE_RATE: st_next.rdata = st_reg.cfg.lane_half;
                link_param_pkg::OFF_SAMPLE_CK: st_next.rdata = st_reg.cfg.fs_mhz;
                link_param_pkg::OFF_STATUS:    st_next.rdata = {st_reg.samples, st_reg.err, st_reg.cfg_err, st_reg.link_en};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg.fsm           <= link_param_pkg::ST_IDLE;
            st_reg.cfg.lanes     <= link_param_pkg::CFG_BYTE_RST;
            st_reg.cfg.conv      <= link_param_pkg::CFG_BYTE_RST;
            st_reg.cfg.octets    <= link_param_pkg::CFG_BYTE_RST;
            st_reg.cfg.frames    <= link_param_pkg::K_MAX;
            st_reg.cfg.res       <= link_param_pkg::RES_MAX;
            st_reg.cfg.ctrl_bits <= '0;
            st_reg.cfg.chip_decimation_ratio       <= link_param_pkg::CFG_BYTE_RST;
            st_reg.cfg.lane_half <= link_param_pkg::CFG_WORD_RST;
            st_reg.cfg.fs_mhz    <= link_param_pkg::CFG_WORD_RST;
            st_reg.pll_reg       <= link_param_pkg::PLL_RANGE_RST;
            st_reg.err           <= '0;
            st_reg.link_en       <= 1'b0;
            st_reg.cfg_err       <= 1'b0;
            st_reg.pll_live      <= link_param_pkg::PLL_RANGE_RST;
            st_reg.samples       <= '0;
            st_reg.rdata         <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata             = st_reg.rdata;
    assign link_enable       = st_reg.link_en;
    assign config_error      = st_reg.cfg_err;
    assign pll_range         = st_reg.pll_live;
    assign samples_per_frame = st_reg.samples;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_apply;
        wr && addr == link_param_pkg::OFF_CONTROL && wdata[link_param_pkg::CTL_APPLY]
        && !wdata[link_param_pkg::CTL_STOP] && st_reg.fsm == link_param_pkg::ST_IDLE;
    endsequence

    sequence s_settle;
        st_reg.fsm == link_param_pkg::ST_CHECK ##1 (link_enable ^ config_error);
    endsequence

    a_apply_settle: assert property (s_apply |=> s_settle)
        else $error("apply did not settle to exactly one outcome");
    a_bad_blocks: assert property (st_reg.fsm == link_param_pkg::ST_CHECK && err_now != '0
                                   |=> config_error && !link_enable)
        else $error("bad configuration enabled the link");
    a_table_hit: assert property (link_enable |-> table_ok && grp != link_param_pkg::GRP_NONE)
        else $error("link enabled with unlisted layout");
    a_rate_window: assert property (link_enable |-> st_reg.cfg.lane_half >= link_param_pkg::RATE_MIN_HALF
                                    && st_reg.cfg.lane_half <= link_param_pkg::RATE_MAX_HALF)
        else $error("link enabled outside lane rate window");
    a_div_limit: assert property (link_enable |-> st_reg.cfg.lane_half <= fs_x_div)
        else $error("lane rate over divider limit");
    a_lcm_limit: assert property (link_enable |-> lcm_val <= link_param_pkg::LCM_MAX)
        else $error("lcm limit exceeded");
    a_pll_band: assert property (link_enable |-> pll_range == pll_code)
        else $error("pll range does not match band");
    a_mf_size: assert property (link_enable |-> st_reg.cfg.frames[1:0] == 2'h0
                                && st_reg.cfg.frames <= link_param_pkg::K_MAX && st_reg.cfg.frames >= k_min)
        else $error("multiframe size illegal");
    a_word_fit: assert property (link_enable |-> st_reg.cfg.res >= link_param_pkg::RES_MIN
                                 && st_reg.cfg.ctrl_bits <= link_param_pkg::CS_MAX)
        else $error("word layout illegal");
    a_out_rate: assert property (link_enable |-> rate_x_dcm == fs_x_mult)
        else $error("output rate mismatch");
    a_live_frozen: assert property (link_enable && wr && addr == link_param_pkg::OFF_FRAMES
                                    && !$past(st_reg.fsm == link_param_pkg::ST_CHECK)
                                    |=> $stable(st_reg.cfg))
        else $error("layout changed while link live");
    a_read_once: assert property (rd ##1 !rd |=> rdata == '0)
        else $error("read data stood beyond one cycle");

endmodule : jesd_link_param_checker

// >>> testbench/link_rx_model.sv
// far-end receiver model latching the frame size at link up
`timescale 1ns/100ps
module link_rx_model (
    input  wire logic       clk,
    input  wire logic       up,
    input  wire logic [7:0] spf,
    output logic      [7:0] frame_len
);
    logic up_reg;
    // frame size taken at link up
    always @(posedge clk) begin
        up_reg <= up;
        if (up && !up_reg) begin
            frame_len <= spf;
        end
    end
endmodule : link_rx_model

// >>> testbench/test_jesd_link_param_checker.sv
// self-checking bench for the link parameter checker
`timescale 1ns/100ps
module test_jesd_link_param_checker;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        link_enable;
    logic        config_error;
    logic [7:0]  pll_range;
    logic [7:0]  samples_per_frame;
    logic [7:0]  frame_len;
    int          err_total = 0;
    int          checks_done = 0;
    int          seed = 32'hd5c25be3;
    int          b, k, n, cs, pll, f;
    bit          ok;
    // rates in window, divider and lcm kept
    int          lane[4] = '{5000, 10000, 20000, 28000};
    int          fs[4] = '{250, 500, 1000, 1400};
    int          code[4] = '{8'h50, 8'h10, 8'h00, 8'h30};
    always #50 clk = ~clk;
    jesd_link_param_checker dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .link_enable(link_enable), .config_error(config_error),
        .pll_range(pll_range), .samples_per_frame(samples_per_frame));
    link_rx_model rx (.clk(clk), .up(link_enable), .spf(samples_per_frame), .frame_len(frame_len));
    ////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_chk(input string nm, input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(nm, rdata, exp);
    endtask : rd_chk
    task end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #400000;
        err_total++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("pll reg", 16'h056e, 16'h0000);
        rd_chk("unmapped", 16'h0123, 16'h0000);
        for (int i = 0; i < 4; i++) wr_reg(i < 3 ? 16'h0580 + i : 16'h0586, 16'h0001);
        for (int i = 0; i < 48; i++) begin
            b = i % 4;
            k = 20 + 4 * ($unsigned($random(seed)) % 4);
            n = 7 + $unsigned($random(seed)) % 2;
            cs = 8 - n;
            pll = code[b];
            f = fs[b];
            case ($unsigned($random(seed)) % 8)
                0: k = k - 7;
                1: k = 16;
                2: cs = cs + 1;
                3: n = 6;
                4: pll = code[(b + 1) % 4];
                5: f = f + 1;
                default: ;
            endcase
            ok = k % 4 == 0 && k >= 20 && k <= 32 && n >= 7 && n <= 8 && cs <= 1 && n + cs <= 8
                && pll == code[b] && f == fs[b];
            wr_reg(16'h0589, 16'h0002);
            wr_reg(16'h0583, k[15:0]);
            wr_reg(16'h0584, n[15:0]);
            wr_reg(16'h0585, cs[15:0]);
            wr_reg(16'h0587, lane[b][15:0]);
            wr_reg(16'h0588, f[15:0]);
            wr_reg(16'h056e, pll[15:0]);
            wr_reg(16'h0589, 16'h0001);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("link_enable", {15'h0000, link_enable}, {15'h0000, ok});
            chk("config_error", {15'h0000, config_error}, {15'h0000, !ok});
            if (ok) begin
                chk("pll_range", {8'h00, pll_range}, code[b][15:0]);
                chk("samples", {8'h00, samples_per_frame}, 16'h0001);
                rd_chk("status", 16'h058a, 16'h0101);
                chk("frame len", {8'h00, frame_len}, 16'h0001);
                wr_reg(16'h0583, 16'h0003);
                rd_chk("frozen k", 16'h0583, k[15:0]);
            end
        end
        end_sim;
    end
endmodule : test_jesd_link_param_checker
